// ---- ucs_pkg.sv ----
package ucs_pkg;

	// ---------------------------------------------------------------
	// Sizes and limits
	// ---------------------------------------------------------------
	localparam int          NUM_EP      = 6;
	localparam int          EP_W        = 3;
	localparam int          SIZE_W      = 10;
	localparam int          BUF_DEPTH   = 512;
	localparam int          IDX_W       = 10;
	localparam logic [9:0]  SIZE_8      = 10'h008;
	localparam logic [9:0]  SIZE_16     = 10'h010;
	localparam logic [9:0]  SIZE_32     = 10'h020;
	localparam logic [9:0]  SIZE_64     = 10'h040;
	localparam logic [9:0]  ISO_SIZE    = 10'h200;
	localparam logic [9:0]  INTR_MAX    = 10'h040;
	localparam logic [9:0]  SETUP_LEN   = 10'h008;
	localparam logic [9:0]  IDX_REQTYPE = 10'h000;
	localparam logic [9:0]  IDX_LEN_LO  = 10'h006;
	localparam logic [9:0]  IDX_LEN_HI  = 10'h007;
	localparam int          DIR_BIT     = 7;
	localparam int          USB_CLK_MHZ = 48;
	localparam int          SYS_CLK_MHZ = 250;

	// ---------------------------------------------------------------
	// Enumerations
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {XFER_CONTROL, XFER_ISO, XFER_BULK, XFER_INTR} ucs_xfer_t;
	typedef enum logic [1:0] {TOK_SETUP, TOK_OUT, TOK_IN} ucs_token_t;
	typedef enum logic [2:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA, HS_ZLP_DATA1} ucs_hs_t;
	typedef enum logic [2:0] {ST_IDLE, ST_DATA_IN, ST_DATA_OUT, ST_STATUS_IN, ST_STATUS_OUT}
		ucs_stage_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic              enable;
		ucs_xfer_t         xfer;
		logic              dual_bank;
		logic [SIZE_W-1:0] size;
		logic              int_en;
		logic              stall;
	} ucs_ep_cfg_t;

	typedef struct packed {
		logic [EP_W-1:0] ep;
		ucs_token_t      kind;
	} ucs_token_in_t;

	typedef struct packed {
		ucs_hs_t         hs;
		logic [EP_W-1:0] ep;
	} ucs_answer_t;

endpackage : ucs_pkg

// ---- ucs_ctrl_engine.sv ----
`timescale 1ns/1ps
// What this block does
// - Endpoint zero carries configuration control traffic
// - Isochronous: one way, 512 bytes, never retried
// - Bulk/control sizes 8,16,32,64; retry allowed
// - Interrupt flows: retry, size at most 64
// - Control only on single-bank endpoints
// - Isochronous only on dual-bank endpoints
// - Stall answers abort a control transfer
// - Status stage opposite in direction to data
// - Status IN returns zero-length DATA1 packet
// - Setup packets acknowledged without firmware
// - Setup sets the endpoint setup-received flag
// - Interrupt held while flag set and enabled
// - After clear, next OUT may overwrite buffer
// - Bus-signal side and register side clocking; here both sides run on sys_clk
module ucs_ctrl_engine (
	input  wire logic                                  sys_clk,             // System clock
	input  wire logic                                  rst_n,               // Async reset
	input  wire ucs_pkg::ucs_ep_cfg_t [ucs_pkg::NUM_EP-1:0] ep_cfg,         // Endpoint setup
	input  wire logic [ucs_pkg::NUM_EP-1:0]            setup_clear,         // Flag clear pulse
	input  wire logic [ucs_pkg::NUM_EP-1:0]            out_release,         // OUT data consumed
	input  wire logic [ucs_pkg::NUM_EP-1:0]            in_ready,            // IN payload staged
	input  wire logic                                  tok_valid,           // Token strobe
	input  wire ucs_pkg::ucs_token_in_t                tok,                 // Token fields
	input  wire logic                                  rx_byte_valid,       // Payload byte strobe
	input  wire logic [7:0]                            rx_byte,             // Payload byte
	input  wire logic                                  pkt_end,             // Data packet end
	input  wire logic                                  pkt_ok,              // CRC and PID good
	input  wire logic [ucs_pkg::EP_W-1:0]              rd_ep,               // Buffer read endpoint
	input  wire logic [ucs_pkg::IDX_W-1:0]             rd_idx,              // Buffer read index
	output logic [7:0]                                 rd_data,             // Buffer read byte
	output logic                                       ans_valid,           // Answer strobe
	output ucs_pkg::ucs_answer_t                       ans,                 // Answer fields
	output logic [ucs_pkg::NUM_EP-1:0]                 setup_received_flag, // Per endpoint
	output logic [ucs_pkg::NUM_EP-1:0]                 out_pending,         // OUT data held
	output logic [ucs_pkg::NUM_EP-1:0]                 ep_irq,              // Per endpoint irq
	output logic                                       irq,                 // Any endpoint irq
	output logic [ucs_pkg::NUM_EP-1:0]                 cfg_bad              // Illegal setup
);

	// ---------------------------------------------------------------
	// Transaction state
	// ---------------------------------------------------------------
	logic [7:0]                  mem [ucs_pkg::NUM_EP][ucs_pkg::BUF_DEPTH];
	logic                        busy;
	logic [ucs_pkg::EP_W-1:0]    cur_ep;
	ucs_pkg::ucs_token_t         cur_kind;
	logic                        cur_store;
	logic [ucs_pkg::IDX_W-1:0]   wr_idx;
	logic                        overflow;
	logic                        req_dir_in;
	logic                        req_len_nz;
	ucs_pkg::ucs_stage_t         stage [ucs_pkg::NUM_EP];

	// ---------------------------------------------------------------
	// Per endpoint legality
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ucs_pkg::NUM_EP; g++) begin : g_cfg
			wire logic [9:0] sz      = ep_cfg[g].size;
			wire logic       std_sz  = (sz == ucs_pkg::SIZE_8) || (sz == ucs_pkg::SIZE_16) ||
			                           (sz == ucs_pkg::SIZE_32) || (sz == ucs_pkg::SIZE_64);
			wire logic       ok_ctl  = std_sz && !ep_cfg[g].dual_bank;
			wire logic       ok_iso  = (sz == ucs_pkg::ISO_SIZE) && ep_cfg[g].dual_bank;
			wire logic       ok_int  = (sz != 10'h000) && (sz <= ucs_pkg::INTR_MAX);
			wire logic       legal   = (ep_cfg[g].xfer == ucs_pkg::XFER_CONTROL) ? ok_ctl :
			                           (ep_cfg[g].xfer == ucs_pkg::XFER_ISO)     ? ok_iso :
			                           (ep_cfg[g].xfer == ucs_pkg::XFER_BULK)    ? std_sz : ok_int;
			// Endpoint zero is always control so the host can configure the device
			wire logic       zero_ok = (g != 0) || (ep_cfg[g].xfer == ucs_pkg::XFER_CONTROL);
			assign cfg_bad[g] = ep_cfg[g].enable && !(legal && zero_ok);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Decode of the current endpoint
	// ---------------------------------------------------------------
	wire ucs_pkg::ucs_ep_cfg_t sel_cfg   = ep_cfg[busy ? cur_ep : tok.ep];
	wire logic [ucs_pkg::EP_W-1:0] sel_ep = busy ? cur_ep : tok.ep;
	wire logic    ep_in_range = (sel_ep < ucs_pkg::EP_W'(ucs_pkg::NUM_EP));
	wire logic    sel_live    = ep_in_range && sel_cfg.enable && !cfg_bad[sel_ep];
	wire logic    sel_ctl     = sel_cfg.xfer == ucs_pkg::XFER_CONTROL;
	wire logic    sel_iso     = sel_cfg.xfer == ucs_pkg::XFER_ISO;
	wire logic    sel_flag    = setup_received_flag[sel_ep];
	wire logic    sel_pend    = out_pending[sel_ep];
	wire ucs_pkg::ucs_stage_t sel_stage = stage[sel_ep];
	wire logic [ucs_pkg::IDX_W-1:0] lim = (cur_kind == ucs_pkg::TOK_SETUP) ?
	                                      ucs_pkg::SETUP_LEN : sel_cfg.size;

	// Payload is kept only for setup, or OUT while the buffer is free
	wire logic    store_ok = (tok.kind == ucs_pkg::TOK_SETUP) ||
	                         (!sel_flag && !sel_pend && !sel_cfg.stall);
	wire logic    wr_en    = busy && rx_byte_valid && cur_store && !overflow && (wr_idx < lim);
	wire logic    status_out = sel_ctl && ((sel_stage == ucs_pkg::ST_DATA_IN) ||
	                           (sel_stage == ucs_pkg::ST_STATUS_OUT));
	wire logic    status_in  = sel_ctl && ((sel_stage == ucs_pkg::ST_DATA_OUT) ||
	                           (sel_stage == ucs_pkg::ST_STATUS_IN));
	wire logic    good_pkt   = pkt_ok && !overflow;

	// ---------------------------------------------------------------
	// Answer selection
	// ---------------------------------------------------------------
	ucs_pkg::ucs_hs_t    next_hs;
	logic                next_set_flag;
	logic                next_set_pend;
	logic                next_stage_ld;
	ucs_pkg::ucs_stage_t next_stage;

	// IN tokens are answered at once; SETUP and OUT at the end of data
	always_comb begin
		next_hs       = ucs_pkg::HS_NONE;
		next_set_flag = 1'b0;
		next_set_pend = 1'b0;
		next_stage_ld = 1'b0;
		next_stage    = ucs_pkg::ST_IDLE;
		if (!busy && tok_valid && tok.kind == ucs_pkg::TOK_IN && sel_live) begin
			if (sel_cfg.stall)
				next_hs = ucs_pkg::HS_STALL;
			else if (status_in) begin
				next_hs       = ucs_pkg::HS_ZLP_DATA1;
				next_stage_ld = 1'b1;
			end else if (sel_ctl && sel_flag)
				next_hs = ucs_pkg::HS_NAK;
			else if (in_ready[sel_ep])
				next_hs = ucs_pkg::HS_DATA;
			else if (!sel_iso)
				next_hs = ucs_pkg::HS_NAK;
		end else if (busy && pkt_end && sel_live && good_pkt) begin
			case (cur_kind)
				ucs_pkg::TOK_SETUP: begin
					// Setup is taken even over a stall, which stays set in ep_cfg
					if (sel_ctl && wr_idx == ucs_pkg::SETUP_LEN) begin
						next_hs       = ucs_pkg::HS_ACK;
						next_set_flag = 1'b1;
						next_stage_ld = 1'b1;
						next_stage    = !req_len_nz ? ucs_pkg::ST_STATUS_IN :
						                req_dir_in  ? ucs_pkg::ST_DATA_IN :
						                              ucs_pkg::ST_DATA_OUT;
					end
				end
				ucs_pkg::TOK_OUT: begin
					if (sel_cfg.stall)
						next_hs = ucs_pkg::HS_STALL;
					else if (status_out && wr_idx == '0) begin
						next_hs       = ucs_pkg::HS_ACK;
						next_stage_ld = 1'b1;
					end else if (!cur_store) begin
						next_hs = sel_iso ? ucs_pkg::HS_NONE : ucs_pkg::HS_NAK;
					end else begin
						next_hs       = sel_iso ? ucs_pkg::HS_NONE : ucs_pkg::HS_ACK;
						next_set_pend = 1'b1;
					end
				end
				default: next_hs = ucs_pkg::HS_NONE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Transaction tracking
	// ---------------------------------------------------------------
	// One clock carries both sides; token and byte strobes arrive already
	// qualified by the bit-rate logic, so no crossing is needed here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy      <= 1'b0;
			cur_ep    <= '0;
			cur_kind  <= ucs_pkg::TOK_SETUP;
			cur_store <= 1'b0;
		end else if (!busy && tok_valid && tok.kind != ucs_pkg::TOK_IN) begin
			busy      <= 1'b1;
			cur_ep    <= tok.ep;
			cur_kind  <= tok.kind;
			cur_store <= store_ok;
		end else if (pkt_end) begin
			busy      <= 1'b0;
		end
	end

	// Byte index, oversize detection and request header capture
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_idx     <= '0;
			overflow   <= 1'b0;
			req_dir_in <= 1'b0;
			req_len_nz <= 1'b0;
		end else if (!busy) begin
			wr_idx     <= '0;
			overflow   <= 1'b0;
			req_dir_in <= 1'b0;
			req_len_nz <= 1'b0;
		end else if (rx_byte_valid) begin
			// An oversize packet gets no answer, so the host retries it
			if (wr_idx >= lim)
				overflow <= 1'b1;
			else
				wr_idx <= wr_idx + 10'h001;
			if (wr_idx == ucs_pkg::IDX_REQTYPE)
				req_dir_in <= rx_byte[ucs_pkg::DIR_BIT];
			if ((wr_idx == ucs_pkg::IDX_LEN_LO || wr_idx == ucs_pkg::IDX_LEN_HI) && rx_byte != 8'h00)
				req_len_nz <= 1'b1;
		end
	end

	// Endpoint buffer; setup bytes overwrite whatever was stored
	always_ff @(posedge sys_clk) begin
		if (wr_en)
			mem[cur_ep][wr_idx[8:0]] <= rx_byte;
		rd_data <= mem[rd_ep][rd_idx[8:0]];
	end

	// Registered answer toward the packet sender
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ans_valid <= 1'b0;
			ans       <= '0;
		end else begin
			ans_valid <= next_hs != ucs_pkg::HS_NONE;
			ans.hs    <= next_hs;
			ans.ep    <= sel_ep;
		end
	end

	// ---------------------------------------------------------------
	// Per endpoint flags and control stage
	// ---------------------------------------------------------------
	generate
		for (g = 0; g < ucs_pkg::NUM_EP; g++) begin : g_ep
			wire logic hit = (sel_ep == ucs_pkg::EP_W'(g));

			// A new setup wins over a clear in the same cycle
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					setup_received_flag[g] <= 1'b0;
				else if (hit && next_set_flag)
					setup_received_flag[g] <= 1'b1;
				else if (setup_clear[g])
					setup_received_flag[g] <= 1'b0;
			end

			// Held OUT payload locks the buffer until firmware releases it or a new setup arrives
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					out_pending[g] <= 1'b0;
				else if (hit && next_set_pend)
					out_pending[g] <= 1'b1;
				else if (out_release[g] || (hit && next_set_flag))
					out_pending[g] <= 1'b0;
			end

			// Control stage sequencing
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					stage[g] <= ucs_pkg::ST_IDLE;
				else if (hit && next_stage_ld)
					stage[g] <= next_stage;
				else if (hit && next_hs == ucs_pkg::HS_STALL)
					stage[g] <= ucs_pkg::ST_IDLE;
			end

			// Interrupt follows the setup flag or held OUT level, gated by its enable
			assign ep_irq[g] = (setup_received_flag[g] || out_pending[g]) &&
			                   ep_cfg[g].int_en;
		end
	endgenerate

	assign irq = |ep_irq;

endmodule : ucs_ctrl_engine

// ---- ucs_ctrl_engine_chk.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker for the control engine
// ---------------------------------------------------------------
module ucs_ctrl_engine_chk (
	input wire logic                            sys_clk,             // Clock
	input wire logic                            rst_n,               // Async reset
	input wire ucs_pkg::ucs_ep_cfg_t [5:0]      ep_cfg,              // Endpoint setup
	input wire logic                            tok_valid,           // Token strobe
	input wire ucs_pkg::ucs_token_in_t          tok,                 // Token
	input wire logic                            rx_byte_valid,       // Byte strobe
	input wire logic                            pkt_end,             // Packet end
	input wire logic                            pkt_ok,              // Packet good
	input wire logic                            ans_valid,           // Answer strobe
	input wire ucs_pkg::ucs_answer_t            ans,                 // Answer
	input wire logic [5:0]                      setup_received_flag, // Flags
	input wire logic [5:0]                      out_pending,         // Held OUT data
	input wire logic [5:0]                      ep_irq,              // Endpoint irq
	input wire logic                            irq,                 // Any irq
	input wire logic [5:0]                      cfg_bad              // Illegal setup
);
	logic                busy;  // Packet in flight
	ucs_pkg::ucs_token_t lk;    // Last taken token kind
	logic [2:0]          le;    // Last taken token endpoint
	logic [3:0]          cnt;   // Payload bytes seen
	logic                lock0; // Endpoint 0 flag when the token came

	// Track the token that owns the packet; tokens while busy are ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{busy, le, cnt, lock0} <= '0;
			lk <= ucs_pkg::TOK_IN;
		end else if (tok_valid && !busy) begin
			busy <= tok.kind != ucs_pkg::TOK_IN;
			lk <= tok.kind;
			{le, cnt, lock0} <= {tok.ep, 4'h0, setup_received_flag[0]};
		end else begin
			if (rx_byte_valid && busy) cnt <= cnt + 4'h1;
			if (pkt_end) busy <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_setup_end;
		pkt_end && pkt_ok && busy && lk == ucs_pkg::TOK_SETUP && le == 3'h0 && cnt == 4'h8
			&& ep_cfg[0].enable && !cfg_bad[0];
	endsequence
	sequence s_in0;
		tok_valid && !busy && tok.kind == ucs_pkg::TOK_IN && tok.ep == 3'h0;
	endsequence
	sequence s_out_end(e);
		pkt_end && busy && lk == ucs_pkg::TOK_OUT && le == e;
	endsequence

	// Expected request levels built from flags and enables, not from ep_irq itself
	wire logic [5:0] ien  = {ep_cfg[5].int_en, ep_cfg[4].int_en, ep_cfg[3].int_en,
	                         ep_cfg[2].int_en, ep_cfg[1].int_en, ep_cfg[0].int_en};
	wire logic [5:0] held = (setup_received_flag | out_pending) & ien;

	a_irq_any_ep: assert property (ep_irq == held && irq == |held)
		else $error("irq not OR of endpoints");
	a_irq_follows_flag: assert property (setup_received_flag[0] && ep_cfg[0].int_en |-> ep_irq[0])
		else $error("irq missing while flag set");
	a_setup_auto_ack: assert property (s_setup_end |=> ans_valid && ans.hs == ucs_pkg::HS_ACK
		&& ans.ep == 3'h0 && setup_received_flag[0]) else $error("setup not acked and flagged");
	a_stall_abort: assert property (s_in0 ##0 (ep_cfg[0].stall && ep_cfg[0].enable && !cfg_bad[0]
		&& !setup_received_flag[0]) |=> ans_valid && ans.hs == ucs_pkg::HS_STALL) else $error("no stall");
	a_zlp_from_in: assert property (ans_valid && ans.hs == ucs_pkg::HS_ZLP_DATA1 |->
		$past(tok_valid && tok.kind == ucs_pkg::TOK_IN) && $past(tok.ep) == ans.ep) else $error("stray zlp");
	a_locked_nak: assert property (s_out_end(3'h0) ##0 lock0 |=> !(ans_valid && ans.hs == ucs_pkg::HS_ACK))
		else $error("out acked while flag set");
	a_iso_no_retry: assert property (s_out_end(3'h1) ##0 ep_cfg[1].xfer == ucs_pkg::XFER_ISO |=> !ans_valid)
		else $error("iso handshake");
	a_ctrl_single_bank: assert property (ep_cfg[2].enable && ep_cfg[2].xfer == ucs_pkg::XFER_CONTROL
		&& ep_cfg[2].dual_bank |-> cfg_bad[2]) else $error("dual bank control accepted");
	a_iso_dual_bank: assert property (ep_cfg[2].enable && ep_cfg[2].xfer == ucs_pkg::XFER_ISO
		&& !ep_cfg[2].dual_bank |-> cfg_bad[2]) else $error("single bank iso accepted");
endmodule : ucs_ctrl_engine_chk

bind ucs_ctrl_engine ucs_ctrl_engine_chk u_chk (.sys_clk, .rst_n, .ep_cfg, .tok_valid, .tok,
	.rx_byte_valid, .pkt_end, .pkt_ok, .ans_valid, .ans, .setup_received_flag, .out_pending, .ep_irq,
	.irq, .cfg_bad);

// ---- ucs_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host controller: tokens and data packets
// ---------------------------------------------------------------
module ucs_host_model (
	input  wire logic             sys_clk,       // Clock
	output logic                  tok_valid,     // Token strobe
	output ucs_pkg::ucs_token_in_t tok,          // Token
	output logic                  rx_byte_valid, // Byte strobe
	output logic [7:0]            rx_byte,       // Byte
	output logic                  pkt_end,       // Packet end
	output logic                  pkt_ok         // Packet good
);
	bit slow; // Idle cycle between bytes
	bit bad;  // Send the packet with a failed check

	initial begin
		{tok_valid, tok, rx_byte_valid, rx_byte, pkt_end, pkt_ok} = '0;
	end

	// Token, payload, end; an empty payload is a zero-length packet
	task automatic send(input ucs_pkg::ucs_token_t k, input logic [2:0] e, input logic [7:0] d[$]);
		ucs_pkg::ucs_token_in_t idle;
		// Released token lines show the inverse, so stale fields cannot look valid
		idle = ucs_pkg::ucs_token_in_t'(~{e, k});
		@(posedge sys_clk);
		#1;
		tok_valid = 1'b1;
		tok = '{ep: e, kind: k};
		foreach (d[i]) begin
			@(posedge sys_clk);
			#1;
			{tok_valid, rx_byte_valid, rx_byte} = {2'b01, d[i]};
			tok = idle;
			if (slow) begin
				@(posedge sys_clk);
				#1;
				{rx_byte_valid, rx_byte} = {1'b0, ~rx_byte}; // Released line shows no stale byte
			end
		end
		@(posedge sys_clk);
		#1;
		{tok_valid, rx_byte_valid, rx_byte, pkt_end, pkt_ok} = {2'b00, ~rx_byte, 1'b1, !bad};
		tok = idle;
		@(posedge sys_clk);
		#1;
		{pkt_end, pkt_ok} = 2'b00;
	endtask : send

	// IN token alone; the answer follows one cycle later
	task automatic in_tok(input logic [2:0] e);
		@(posedge sys_clk);
		#1;
		tok_valid = 1'b1;
		tok = '{ep: e, kind: ucs_pkg::TOK_IN};
		@(posedge sys_clk);
		#1;
		tok_valid = 1'b0;
		tok = ucs_pkg::ucs_token_in_t'(~{e, ucs_pkg::TOK_IN});
	endtask : in_tok
endmodule : ucs_host_model

// ---- ucs_ctrl_engine_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
// ---------------------------------------------------------------
// Self-checking bench for the control engine
// ---------------------------------------------------------------
module ucs_ctrl_engine_bench;
	logic sys_clk, rst_n, tok_valid, rx_byte_valid, pkt_end, pkt_ok, ans_valid, irq;
	logic [5:0] setup_clear, out_release, in_ready, setup_received_flag;
	logic [5:0] out_pending, ep_irq, cfg_bad;
	logic [7:0] rx_byte, rd_data;
	logic [2:0] rd_ep;
	logic [9:0] rd_idx;
	ucs_pkg::ucs_ep_cfg_t [5:0] ep_cfg;
	ucs_pkg::ucs_token_in_t     tok;
	ucs_pkg::ucs_answer_t       ans;
	logic [7:0] s[$], o[$], nul[$];
	int err_count, n_tests;

	ucs_ctrl_engine dut (.sys_clk, .rst_n, .ep_cfg, .setup_clear, .out_release, .in_ready,
		.tok_valid, .tok, .rx_byte_valid, .rx_byte, .pkt_end, .pkt_ok, .rd_ep, .rd_idx,
		.rd_data, .ans_valid, .ans, .setup_received_flag, .out_pending, .ep_irq, .irq, .cfg_bad);
	ucs_host_model host (.sys_clk, .tok_valid, .tok, .rx_byte_valid, .rx_byte, .pkt_end, .pkt_ok);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic ucs_pkg::ucs_ep_cfg_t mk(logic [1:0] x, logic d, logic [9:0] z);
		mk = '{enable: 1'b1, xfer: ucs_pkg::ucs_xfer_t'(x), dual_bank: d, size: z, int_en: 1'b1,
			stall: 1'b0};
	endfunction : mk

	// A missing answer reads as HS_NONE on endpoint 0
	task automatic want(input ucs_pkg::ucs_hs_t h, input logic [2:0] e);
		ucs_pkg::ucs_answer_t a;
		a = '0;
		for (int i = 0; i < 4; i++) begin
			if (ans_valid === 1'b1) begin
				a = ans;
				break;
			end
			@(posedge sys_clk);
			#1;
		end
		`CHK({a.hs, a.ep}, {h, e})
	endtask : want

	task automatic rd_chk(input logic [9:0] i, input logic [7:0] v);
		{rd_ep, rd_idx} = {3'h0, i};
		@(posedge sys_clk);
		#1;
		`CHK(rd_data, v)
	endtask : rd_chk

	// Firmware pulse on endpoint 0: flag clear or OUT release
	task automatic pulse(input logic rel);
		{out_release[0], setup_clear[0]} = {rel, !rel};
		@(posedge sys_clk);
		#1;
		{setup_clear, out_release} = '0;
	endtask : pulse

	// Table {bad, xfer, dual, size} tried on endpoint 2; changes stay one cycle apart
	task automatic t_cfg;
		logic [13:0] t[10] = '{14'h0008, 14'h2440, 14'h2018, 14'h1020, 14'h3048,
			14'h0e00, 14'h2a00, 14'h2c40, 14'h1840, 14'h3841};
		foreach (t[i]) begin
			ep_cfg[2] = mk(t[i][12:11], t[i][10], t[i][9:0]);
			#4;
			`CHK(cfg_bad[2], t[i][13])
		end
		ep_cfg[2] = '0;
		ep_cfg[0].xfer = ucs_pkg::XFER_BULK;
		#4;
		`CHK(cfg_bad[0], 1'b1)
		ep_cfg[0].xfer = ucs_pkg::XFER_CONTROL;
		#4;
		`CHK(cfg_bad[0], 1'b0)
		$display("test cfg finished");
	endtask : t_cfg

	// Control write: setup locks the buffer until firmware clears the flag
	task automatic t_write;
		s = {8'h00, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
		host.send(ucs_pkg::TOK_SETUP, 3'h0, s);
		want(ucs_pkg::HS_ACK, 3'h0);
		`CHK({setup_received_flag[0], ep_irq[0], irq}, 3'h7)
		foreach (s[i]) rd_chk(10'(i), s[i]);
		ep_cfg[0].int_en = 1'b0;
		#4;
		`CHK({setup_received_flag[0], ep_irq[0], irq}, 3'h4)
		ep_cfg[0].int_en = 1'b1;
		o = {};
		repeat (8) o.push_back(8'ha5);
		host.send(ucs_pkg::TOK_OUT, 3'h0, o);
		want(ucs_pkg::HS_NAK, 3'h0);
		rd_chk(10'h000, 8'h00);
		pulse(1'b0);
		`CHK(setup_received_flag[0], 1'b0)
		host.send(ucs_pkg::TOK_OUT, 3'h0, o);
		want(ucs_pkg::HS_ACK, 3'h0);
		rd_chk(10'h000, 8'ha5);
		`CHK({out_pending[0], ep_irq[0]}, 2'h3)
		pulse(1'b1);
		`CHK(out_pending[0], 1'b0)
		host.in_tok(3'h0);
		want(ucs_pkg::HS_ZLP_DATA1, 3'h0);
		$display("test write finished");
	endtask : t_write

	// Control read: data IN, then a zero-length OUT status
	task automatic t_read;
		host.send(ucs_pkg::TOK_SETUP, 3'h0, {8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08, 8'h00});
		want(ucs_pkg::HS_ACK, 3'h0);
		host.in_tok(3'h0);
		want(ucs_pkg::HS_NAK, 3'h0);
		pulse(1'b0);
		in_ready[0] = 1'b1;
		host.in_tok(3'h0);
		want(ucs_pkg::HS_DATA, 3'h0);
		in_ready[0] = 1'b0;
		host.send(ucs_pkg::TOK_OUT, 3'h0, nul);
		want(ucs_pkg::HS_ACK, 3'h0);
		$display("test read finished");
	endtask : t_read

	// No-data request from a slow host, then stall abort and iso silence
	task automatic t_misc;
		host.slow = 1'b1;
		host.send(ucs_pkg::TOK_SETUP, 3'h0, {8'h00, 8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		host.slow = 1'b0;
		want(ucs_pkg::HS_ACK, 3'h0);
		pulse(1'b0);
		host.in_tok(3'h0);
		want(ucs_pkg::HS_ZLP_DATA1, 3'h0);
		ep_cfg[0].stall = 1'b1;
		host.in_tok(3'h0);
		want(ucs_pkg::HS_STALL, 3'h0);
		host.send(ucs_pkg::TOK_OUT, 3'h0, o);
		want(ucs_pkg::HS_STALL, 3'h0);
		host.send(ucs_pkg::TOK_SETUP, 3'h0, s);
		want(ucs_pkg::HS_ACK, 3'h0);
		ep_cfg[0].stall = 1'b0;
		pulse(1'b0);
		host.send(ucs_pkg::TOK_OUT, 3'h1, {8'h01, 8'h02, 8'h03, 8'h04});
		want(ucs_pkg::HS_NONE, 3'h0);
		// A failed check or an oversize setup gets no answer, so the host retries
		host.bad = 1'b1;
		host.send(ucs_pkg::TOK_OUT, 3'h0, o);
		host.bad = 1'b0;
		want(ucs_pkg::HS_NONE, 3'h0);
		s.push_back(8'h00);
		host.send(ucs_pkg::TOK_SETUP, 3'h0, s);
		want(ucs_pkg::HS_NONE, 3'h0);
		`CHK(setup_received_flag[0], 1'b0)
		$display("test misc finished");
	endtask : t_misc

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// Whole run is under two hundred cycles; this bound of 5000 cycles is generous
	initial begin
		#20000;
		err_count++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		ep_cfg = '0;
		ep_cfg[0] = mk(2'h0, 1'b0, ucs_pkg::SIZE_64);
		ep_cfg[1] = mk(2'h1, 1'b1, ucs_pkg::ISO_SIZE);
		{setup_clear, out_release, in_ready, rd_ep, rd_idx} = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		t_cfg();
		t_write();
		t_read();
		t_misc();
		end_of_test();
	end
endmodule : ucs_ctrl_engine_bench
